// ### mfiu_alu.sv
`timescale 1ns/1ps
module mfiu_alu (
    // Operands and results
    mfiu_exec_if.alu ex
);

    // ************************************************************
    // Result, zero and carry
    // ************************************************************

    // Pure combinational datapath; the sequencer registers its answers
    always_comb begin
        logic dst_below;
        dst_below = $signed(ex.dst_val) < $signed(ex.src_val);
        ex.result = ex.dst_val;
        ex.c_next = ex.c_in;  // Inserts leave C alone
        ex.legal = 1'b1;
        unique case (ex.op)
            mfiu_pkg::signed_lower_limit_op: begin
                ex.result = dst_below ? ex.src_val : ex.dst_val;  // Larger signed value
                ex.c_next = dst_below;
            end
            mfiu_pkg::register_copy_op: begin
                ex.result = ex.src_val;
                ex.c_next = ex.src_val[mfiu_pkg::SIGN_BIT];
            end
            mfiu_pkg::dest_field_insert_op: begin
                ex.result = mfiu_pkg::mfiu_insert(ex.dst_val, ex.src_val, mfiu_pkg::DFIELD_LO);
            end
            mfiu_pkg::opcode_field_insert_op: begin
                ex.result = mfiu_pkg::mfiu_insert(ex.dst_val, ex.src_val, mfiu_pkg::IFIELD_LO);
            end
            mfiu_pkg::src_field_insert_op: begin
                ex.result = mfiu_pkg::mfiu_insert(ex.dst_val, ex.src_val, mfiu_pkg::SFIELD_LO);
            end
            mfiu_pkg::no_op: begin
                ex.legal = 1'b0;
            end
        endcase
        // Limit looks at the source only; moves look at what they produce
        if (ex.op == mfiu_pkg::signed_lower_limit_op) begin
            ex.z_next = (ex.src_val == mfiu_pkg::WORD_RESET);
        end else begin
            ex.z_next = (ex.result == mfiu_pkg::WORD_RESET);
        end
    end

endmodule : mfiu_alu

// ### mfiu_core.sv
`timescale 1ns/1ps
module mfiu_core (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Instruction issue
    input wire logic i_instr_valid,
    input wire logic [mfiu_pkg::WORD_W-1:0] i_instr,
    input wire logic [mfiu_pkg::WORD_W-1:0] i_dest_val,
    input wire logic [mfiu_pkg::WORD_W-1:0] i_src_reg_val,
    output logic o_ready,
    // Fetch sequencing
    output logic o_fetch_next,
    // Write-back
    output logic o_wb_en,
    output logic [mfiu_pkg::FIELD_W-1:0] o_wb_addr,
    output logic [mfiu_pkg::WORD_W-1:0] o_wb_data,
    // Flags
    output logic o_z_flag,
    output logic o_c_flag,
    // Status
    output logic o_retire,
    output logic o_bad_instr
);

    // ************************************************************
    // Sequencer state
    // ************************************************************

    typedef enum {
        st_idle,
        st_decode,
        st_operand,
        st_fetch,
        st_commit
    } mfiu_state_type;

    mfiu_state_type state;
    mfiu_state_type next_state;
    mfiu_pkg::mfiu_op_type op_q;
    logic [mfiu_pkg::WORD_W-1:0] instr_q;
    logic [mfiu_pkg::WORD_W-1:0] dst_q;
    logic [mfiu_pkg::WORD_W-1:0] src_reg_q;
    logic [mfiu_pkg::WORD_W-1:0] src_q;
    logic [mfiu_pkg::WORD_W-1:0] result_q;
    logic z_calc_q;
    logic c_calc_q;
    logic legal_q;
    logic accept;

    mfiu_exec_if ex ();

    mfiu_alu u_alu (
        .ex(ex.alu)
    );

    // A new instruction is taken while idle or in the last clock of the previous one
    assign accept = o_ready && i_instr_valid;

    // Fixed four-clock walk per instruction, legal or not
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: next_state = accept ? st_decode : st_idle;
            st_decode: next_state = st_operand;
            st_operand: next_state = st_fetch;
            st_fetch: next_state = st_commit;
            st_commit: next_state = accept ? st_decode : st_idle;
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Ready is registered so the issuing sequencer sees a clean level
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ready <= 1'b1;
        end else begin
            o_ready <= (next_state == st_idle) || (next_state == st_commit);
        end
    end

    // ************************************************************
    // Capture and decode
    // ************************************************************

    // Instruction and operands are frozen for the whole walk
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            instr_q <= mfiu_pkg::WORD_RESET;
            dst_q <= mfiu_pkg::WORD_RESET;
            src_reg_q <= mfiu_pkg::WORD_RESET;
            op_q <= mfiu_pkg::no_op;
        end else if (accept) begin
            instr_q <= i_instr;
            dst_q <= i_dest_val;
            src_reg_q <= i_src_reg_val;
            op_q <= mfiu_pkg::mfiu_decode(i_instr[mfiu_pkg::OPC_HI:mfiu_pkg::OPC_LO],
                                          i_instr[mfiu_pkg::COND_HI:mfiu_pkg::COND_LO]);
        end
    end

    // Source operand: register content or zero-extended immediate field
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_q <= mfiu_pkg::WORD_RESET;
        end else if (state == st_decode) begin
            if (instr_q[mfiu_pkg::IMM_BIT]) begin
                src_q <= {{(mfiu_pkg::WORD_W-mfiu_pkg::FIELD_W){1'b0}},
                          instr_q[mfiu_pkg::SRC_HI:mfiu_pkg::SRC_LO]};
            end else begin
                src_q <= src_reg_q;
            end
        end
    end

    // ************************************************************
    // Execute
    // ************************************************************

    assign ex.op = op_q;
    assign ex.dst_val = dst_q;
    assign ex.src_val = src_q;
    assign ex.c_in = o_c_flag;

    // Results are latched so the commit clock has no long path behind it
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            result_q <= mfiu_pkg::WORD_RESET;
            z_calc_q <= mfiu_pkg::FLAG_RESET;
            c_calc_q <= mfiu_pkg::FLAG_RESET;
            legal_q <= 1'b0;
        end else if (state == st_operand) begin
            result_q <= ex.result;
            z_calc_q <= ex.z_next;
            c_calc_q <= ex.c_next;
            legal_q <= ex.legal;
        end
    end

    // ************************************************************
    // Fetch and commit
    // ************************************************************

    // The following instruction is fetched one clock before write-back,
    // so code patched by an insert needs one instruction in between
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_fetch_next <= 1'b0;
        end else begin
            o_fetch_next <= (state == st_operand);
        end
    end

    // Write-back, suppressed by the no-result effect or a bad instruction
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_en <= 1'b0;
            o_wb_addr <= mfiu_pkg::ADDR_RESET;
            o_wb_data <= mfiu_pkg::WORD_RESET;
        end else if (state == st_fetch) begin
            o_wb_en <= legal_q && instr_q[mfiu_pkg::REFF_BIT];
            o_wb_addr <= instr_q[mfiu_pkg::DST_HI:mfiu_pkg::DST_LO];
            o_wb_data <= result_q;
        end else begin
            o_wb_en <= 1'b0;
        end
    end

    // Z follows the zero-flag effect
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_z_flag <= mfiu_pkg::FLAG_RESET;
        end else if (state == st_fetch && legal_q && instr_q[mfiu_pkg::ZEFF_BIT]) begin
            o_z_flag <= z_calc_q;
        end
    end

    // C follows the carry effect; inserts carry C back unchanged
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_c_flag <= mfiu_pkg::FLAG_RESET;
        end else if (state == st_fetch && legal_q && instr_q[mfiu_pkg::CEFF_BIT]) begin
            o_c_flag <= c_calc_q;
        end
    end

    // Retire pulse for every instruction, bad pulse for unknown or conditional ones
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_retire <= 1'b0;
            o_bad_instr <= 1'b0;
        end else begin
            o_retire <= (state == st_fetch);
            o_bad_instr <= (state == st_fetch) && !legal_q;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking chk_clk @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    logic commit_ok;
    assign commit_ok = (state == st_commit) && legal_q;

    chk_limit_larger: assert property (
        (o_wb_en && op_q == mfiu_pkg::signed_lower_limit_op)
        |-> o_wb_data == (($signed(dst_q) < $signed(src_q)) ? src_q : dst_q))
        else $error("limit did not write the larger signed value");

    chk_limit_zero: assert property (
        (commit_ok && op_q == mfiu_pkg::signed_lower_limit_op && instr_q[mfiu_pkg::ZEFF_BIT])
        |-> o_z_flag == (src_q == mfiu_pkg::WORD_RESET))
        else $error("limit Z does not reflect a zero source");

    chk_limit_carry: assert property (
        (commit_ok && op_q == mfiu_pkg::signed_lower_limit_op && instr_q[mfiu_pkg::CEFF_BIT])
        |-> o_c_flag == ($signed(dst_q) < $signed(src_q)))
        else $error("limit C does not reflect signed compare");

    chk_copy_value: assert property (
        (commit_ok && op_q == mfiu_pkg::register_copy_op)
        |-> (!o_wb_en || o_wb_data == src_q)
            && (!instr_q[mfiu_pkg::CEFF_BIT] || o_c_flag == src_q[mfiu_pkg::SIGN_BIT]))
        else $error("copy value or carry wrong");

    chk_move_zero: assert property (
        (commit_ok && op_q != mfiu_pkg::signed_lower_limit_op && instr_q[mfiu_pkg::ZEFF_BIT])
        |-> o_z_flag == (result_q == mfiu_pkg::WORD_RESET))
        else $error("move Z does not reflect a zero result");

    chk_dfield_insert: assert property (
        (o_wb_en && op_q == mfiu_pkg::dest_field_insert_op)
        |-> o_wb_data[mfiu_pkg::DST_HI:mfiu_pkg::DST_LO] == src_q[mfiu_pkg::SRC_HI:mfiu_pkg::SRC_LO]
            && o_wb_data[mfiu_pkg::WORD_W-1:mfiu_pkg::DST_HI+1] == dst_q[mfiu_pkg::WORD_W-1:mfiu_pkg::DST_HI+1]
            && o_wb_data[mfiu_pkg::DST_LO-1:0] == dst_q[mfiu_pkg::DST_LO-1:0])
        else $error("destination field insert touched wrong bits");

    chk_ifield_insert: assert property (
        (o_wb_en && op_q == mfiu_pkg::opcode_field_insert_op)
        |-> o_wb_data == {src_q[mfiu_pkg::SRC_HI:mfiu_pkg::SRC_LO], dst_q[mfiu_pkg::IFIELD_LO-1:0]})
        else $error("opcode field insert touched wrong bits");

    chk_sfield_insert: assert property (
        (o_wb_en && op_q == mfiu_pkg::src_field_insert_op)
        |-> o_wb_data == {dst_q[mfiu_pkg::WORD_W-1:mfiu_pkg::SRC_HI+1], src_q[mfiu_pkg::SRC_HI:mfiu_pkg::SRC_LO]})
        else $error("source field insert touched wrong bits");

    chk_no_result: assert property (
        (state == st_commit) |-> o_wb_en == (legal_q && instr_q[mfiu_pkg::REFF_BIT]))
        else $error("write-back does not follow the no-result effect");

    chk_four_clocks: assert property (
        accept |=> (state == st_decode) ##1 (state == st_operand) ##1 (state == st_fetch)
                   ##1 (state == st_commit && o_retire && o_ready))
        else $error("instruction did not finish in four clocks");

    chk_fetch_first: assert property (
        o_fetch_next |=> o_retire && !o_fetch_next)
        else $error("next fetch not one clock ahead of commit");

    chk_imm_select: assert property (
        (state == st_operand && instr_q[mfiu_pkg::IMM_BIT])
        |-> src_q == (instr_q & mfiu_pkg::FIELD_MASK))
        else $error("immediate source not zero-extended field");

    chk_carry_hold: assert property (
        (state == st_fetch && !(legal_q && instr_q[mfiu_pkg::CEFF_BIT]
                                && (op_q == mfiu_pkg::signed_lower_limit_op || op_q == mfiu_pkg::register_copy_op)))
        |=> o_c_flag == $past(o_c_flag))
        else $error("C changed without a defined carry effect");

    // ************************************************************
    // Pulse shape and flag hold checks
    // ************************************************************

    // The bench only looks at the retire clock, so stray pulses and
    // flag drift between instructions are caught here instead

    chk_pulse_align: assert property (
        (o_wb_en || o_bad_instr)
        |-> o_retire)
        else $error("write or bad pulse outside the commit clock");

    chk_idle_quiet: assert property (
        (state == st_idle)
        |-> !o_wb_en && !o_retire)
        else $error("write or retire seen while idle");

    chk_wb_addr: assert property (
        o_wb_en
        |-> o_wb_addr == instr_q[mfiu_pkg::DST_HI:mfiu_pkg::DST_LO])
        else $error("write address is not the destination field");

    chk_bad_inert: assert property (
        (o_retire && o_bad_instr)
        |-> !o_wb_en && $stable(o_z_flag) && $stable(o_c_flag))
        else $error("refused word wrote a result or a flag");

    chk_ready_busy: assert property (
        (state == st_decode || state == st_operand || state == st_fetch)
        |-> !o_ready)
        else $error("ready raised in the middle of an instruction");

    chk_fetch_slot: assert property (
        o_fetch_next
        |-> state == st_fetch && !o_wb_en)
        else $error("next fetch outside the fetch clock");

    chk_zero_hold: assert property (
        (state == st_fetch && !(legal_q && instr_q[mfiu_pkg::ZEFF_BIT]))
        |=> $stable(o_z_flag))
        else $error("Z changed without a zero-flag effect");

    // Z of a copy is judged on the source, so a broken result latch still shows up
    chk_copy_zero: assert property (
        (commit_ok && op_q == mfiu_pkg::register_copy_op && instr_q[mfiu_pkg::ZEFF_BIT])
        |-> o_z_flag == (src_q == mfiu_pkg::WORD_RESET))
        else $error("copy Z does not reflect a zero source");

    // Inserts have no defined carry, so C must survive even with the carry effect set
    chk_insert_carry: assert property (
        (commit_ok && op_q inside {mfiu_pkg::dest_field_insert_op, mfiu_pkg::opcode_field_insert_op,
                                   mfiu_pkg::src_field_insert_op})
        |-> $stable(o_c_flag))
        else $error("field insert changed C");

    cov_bad_word: cover property (o_retire && o_bad_instr);
    cov_limit_written: cover property (o_wb_en && op_q == mfiu_pkg::signed_lower_limit_op);
    cov_copy_carry: cover property (commit_ok && op_q == mfiu_pkg::register_copy_op && o_c_flag);
    cov_insert_suppressed: cover property (commit_ok && op_q == mfiu_pkg::dest_field_insert_op && !o_wb_en);
    cov_back_to_back: cover property ((state == st_commit) && accept);

endmodule : mfiu_core

// ### mfiu_exec_if.sv
`timescale 1ns/1ps
// Operands to the datapath and its results back
interface mfiu_exec_if;
    mfiu_pkg::mfiu_op_type op;
    logic [mfiu_pkg::WORD_W-1:0] dst_val;
    logic [mfiu_pkg::WORD_W-1:0] src_val;
    logic c_in;
    logic [mfiu_pkg::WORD_W-1:0] result;
    logic z_next;
    logic c_next;
    logic legal;

    modport issuer (output op, output dst_val, output src_val, output c_in,
                    input result, input z_next, input c_next, input legal);
    modport alu (input op, input dst_val, input src_val, input c_in,
                 output result, output z_next, output c_next, output legal);
endinterface : mfiu_exec_if

// ### mfiu_pkg.sv
// How it works
// - Signed lower limit picks larger signed operand
// - Larger signed operand written unless suppressed
// - Lower limit sets Z when source is zero
// - Lower limit sets C when dest below source
// - Source is register or 9-bit immediate
// - Copy opcode 101000, condition 1111, four clocks
// - Copy loads C from source bit 31
// - Moves set Z when moved result is zero
// - Moves write back unless no-result effect given
// - Destination insert replaces bits 17..9 only
// - Destination insert opcode 010101, four clocks
// - Opcode insert replaces bits 31..23 only
// - Opcode insert opcode 010110, four clocks
// - Source insert replaces bits 8..0 only
// - Source insert opcode 010100, four clocks
// - Next fetch happens before result is committed
//
package mfiu_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int WORD_W = 32;
    localparam int FIELD_W = 9;
    localparam int OPC_W = 6;
    localparam int COND_W = 4;

    // ************************************************************
    // Instruction word layout
    // ************************************************************
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int ZEFF_BIT = 25;
    localparam int CEFF_BIT = 24;
    localparam int REFF_BIT = 23;
    localparam int IMM_BIT = 22;
    localparam int COND_HI = 21;
    localparam int COND_LO = 18;
    localparam int DST_HI = 17;
    localparam int DST_LO = 9;
    localparam int SRC_HI = 8;
    localparam int SRC_LO = 0;
    localparam int SIGN_BIT = 31;

    // Low bit of each insertable field
    localparam int IFIELD_LO = 23;
    localparam int DFIELD_LO = 9;
    localparam int SFIELD_LO = 0;
    localparam logic [WORD_W-1:0] FIELD_MASK = 32'h000001FF;

    // ************************************************************
    // Opcodes and condition
    // ************************************************************
    localparam logic [OPC_W-1:0] OPC_SIGNED_LOWER_LIMIT = 6'h10;
    localparam logic [OPC_W-1:0] OPC_REGISTER_COPY = 6'h28;
    localparam logic [OPC_W-1:0] OPC_DEST_FIELD_INSERT = 6'h15;
    localparam logic [OPC_W-1:0] OPC_OPCODE_FIELD_INSERT = 6'h16;
    localparam logic [OPC_W-1:0] OPC_SRC_FIELD_INSERT = 6'h14;
    localparam logic [COND_W-1:0] COND_ALWAYS = 4'hF;

    // ************************************************************
    // Timing and reset values
    // ************************************************************
    localparam int EXEC_CLOCKS = 4;
    localparam logic FLAG_RESET = 1'h0;
    localparam logic [WORD_W-1:0] WORD_RESET = 32'h00000000;
    localparam logic [FIELD_W-1:0] ADDR_RESET = 9'h000;

    typedef enum {
        no_op,
        signed_lower_limit_op,
        register_copy_op,
        dest_field_insert_op,
        opcode_field_insert_op,
        src_field_insert_op
    } mfiu_op_type;

    // Only the unconditional form is executed here
    function automatic mfiu_op_type mfiu_decode(input logic [OPC_W-1:0] opc, input logic [COND_W-1:0] cond);
        mfiu_op_type op;
        op = no_op;
        if (cond == COND_ALWAYS) begin
            unique case (opc)
                OPC_SIGNED_LOWER_LIMIT: op = signed_lower_limit_op;
                OPC_REGISTER_COPY: op = register_copy_op;
                OPC_DEST_FIELD_INSERT: op = dest_field_insert_op;
                OPC_OPCODE_FIELD_INSERT: op = opcode_field_insert_op;
                OPC_SRC_FIELD_INSERT: op = src_field_insert_op;
                default: op = no_op;
            endcase
        end
        return op;
    endfunction : mfiu_decode

    // Replace nine bits at a given position, keep the rest
    function automatic logic [WORD_W-1:0] mfiu_insert(input logic [WORD_W-1:0] dst, input logic [WORD_W-1:0] val,
                                                      input int lo);
        return (dst & ~(FIELD_MASK << lo)) | ((val & FIELD_MASK) << lo);
    endfunction : mfiu_insert

endpackage : mfiu_pkg

// ### move_field_insert_unit_bench.sv
`timescale 1ns/1ps
module move_field_insert_unit_bench;

    // ************************************************************
    // Stimulus, outputs and bookkeeping
    // ************************************************************
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_instr_valid = 1'b0;
    logic [mfiu_pkg::WORD_W-1:0] i_instr = 32'h00000000;
    logic [mfiu_pkg::WORD_W-1:0] i_dest_val = 32'h00000000;
    logic [mfiu_pkg::WORD_W-1:0] i_src_reg_val = 32'h00000000;
    logic o_ready, o_fetch_next, o_wb_en, o_z_flag, o_c_flag, o_retire, o_bad_instr;
    logic [mfiu_pkg::FIELD_W-1:0] o_wb_addr;
    logic [mfiu_pkg::WORD_W-1:0] o_wb_data;
    typedef struct packed {
        logic wb;
        logic [8:0] addr;
        logic [31:0] data;
        logic z;
        logic c;
        logic bad;
    } mfiu_exp_type;
    mfiu_exp_type exp_q[$];
    mfiu_exp_type got_e;
    int err_total = 0;
    int samples_checked = 0;
    logic z_model = 1'b0;
    logic c_model = 1'b0;
    logic fetch_d = 1'b0;
    logic [2:0] rdy_h = 3'h7;
    logic [5:0] ops [5] = '{6'h10, 6'h28, 6'h15, 6'h16, 6'h14};
    logic [31:0] dv [8] = '{32'h00000001, 32'h00000001, 32'h00000001, 32'h00000000,
                            32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000000, 32'hFFFFFFFF};
    logic [31:0] sv [8] = '{32'h00000002, 32'h00000000, 32'hFFFFFFFF, 32'h00000001,
                            32'h00000001, 32'h00000000, 32'h000001FF, 32'h000001FF};

    mfiu_core i_dut (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_instr_valid(i_instr_valid),
        .i_instr(i_instr),
        .i_dest_val(i_dest_val),
        .i_src_reg_val(i_src_reg_val),
        .o_ready(o_ready),
        .o_fetch_next(o_fetch_next),
        .o_wb_en(o_wb_en),
        .o_wb_addr(o_wb_addr),
        .o_wb_data(o_wb_data),
        .o_z_flag(o_z_flag),
        .o_c_flag(o_c_flag),
        .o_retire(o_retire),
        .o_bad_instr(o_bad_instr)
    );

    // 10 MHz core clock
    initial forever #50 i_core_clk = ~i_core_clk;

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic test_done();
        $display("Checked %0d samples, %0d mismatches", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
        samples_checked++;
        if (got !== want) begin
            err_total++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, want);
        end
    endtask : check

    // Word layout: opcode, ZCRI effects, condition, dest address, source field
    function automatic logic [31:0] mk(input logic [5:0] op, input logic [3:0] zcri, input logic [3:0] cnd,
                                       input logic [8:0] da, input logic [8:0] sf);
        return {op, zcri, cnd, da, sf};
    endfunction : mk

    // Offer one instruction, note the expected outcome once it is taken
    task automatic issue(input logic [31:0] ins, input logic [31:0] d, input logic [31:0] s);
        mfiu_exp_type e;
        logic [31:0] v;
        logic [31:0] r;
        logic known;
        int n;
        i_instr <= ins;
        i_dest_val <= d;
        i_src_reg_val <= s;
        i_instr_valid <= 1'b1;
        v = ins[22] ? {23'h000000, ins[8:0]} : s;
        known = (ins[21:18] == 4'hF);
        case (ins[31:26])
            6'h10: r = ($signed(d) > $signed(v)) ? d : v;
            6'h28: r = v;
            6'h15: r = {d[31:18], v[8:0], d[8:0]};
            6'h16: r = {v[8:0], d[22:0]};
            6'h14: r = {d[31:9], v[8:0]};
            default: begin
                r = d;
                known = 1'b0;
            end
        endcase
        // Flags only move for legal words with the effect bit set
        if (known && ins[25]) begin
            z_model = (ins[31:26] == 6'h10 || ins[31:26] == 6'h28) ? (v == 0) : (r == 0);
        end
        if (known && ins[24] && ins[31:26] == 6'h10) c_model = $signed(d) < $signed(v);
        if (known && ins[24] && ins[31:26] == 6'h28) c_model = v[31];
        e = '{wb: known & ins[23], addr: ins[17:9], data: r, z: z_model, c: c_model, bad: ~known};
        for (n = 0; n < 12; n++) begin
            @(negedge i_core_clk);
            if (o_ready === 1'b1) break;
            @(posedge i_core_clk);
        end
        if (n == 12) begin
            err_total++;
            $display("ERROR at %0t: ready wait ran out got %h expected %h", $time, 1'b0, 1'b1);
            test_done();
        end
        @(posedge i_core_clk);
        exp_q.push_back(e);
    endtask : issue

    // ************************************************************
    // Monitor: every retire takes the oldest note
    // ************************************************************
    always @(negedge i_core_clk) begin
        if (i_rst_b === 1'b1 && o_retire === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0, "unexpected retire");
            end else begin
                got_e = exp_q.pop_front();
                check(32'(fetch_d), 32'h1, "fetch before commit");
                check(32'({o_ready, rdy_h}), 32'h8, "ready pattern over 4 clocks");
                check(32'(o_bad_instr), 32'(got_e.bad), "bad flag");
                check(32'(o_wb_en), 32'(got_e.wb), "write enable");
                if (got_e.wb) check(o_wb_data, got_e.data, "result");
                if (got_e.wb) check(32'(o_wb_addr), 32'(got_e.addr), "address");
                check(32'(o_z_flag), 32'(got_e.z), "Z flag");
                check(32'(o_c_flag), 32'(got_e.c), "C flag");
            end
        end
        fetch_d = o_fetch_next;
        rdy_h = {rdy_h[1:0], o_ready};
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int i;
        int k;
        void'($urandom(28492));
        repeat (6) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(posedge i_core_clk);
        // Boundary operand pairs on every opcode, back to back
        for (i = 0; i < 5; i++) begin
            for (k = 0; k < 8; k++) begin
                issue(mk(ops[i], 4'hE, 4'hF, 9'(k), 9'(k)), dv[k], sv[k]);
            end
        end
        $display("Test boundary operands done");
        // Every effect combination, immediate and no-result included
        for (k = 0; k < 16; k++) begin
            issue(mk(ops[k % 5], 4'(k), 4'hF, 9'($urandom), 9'($urandom)), $urandom, $urandom);
        end
        $display("Test effect bits done");
        // Conditional and unknown words retire without effect
        issue(mk(6'h28, 4'hF, 4'h7, 9'h011, 9'h000), 32'h12345678, 32'h00000000);
        issue(mk(6'h3F, 4'hF, 4'hF, 9'h012, 9'h000), 32'h12345678, 32'h00000000);
        issue(mk(6'h15, 4'hE, 4'h0, 9'h013, 9'h1FF), 32'h00000000, 32'h000001FF);
        $display("Test refused words done");
        // Random traffic across all opcodes
        for (k = 0; k < 60; k++) begin
            issue(mk(ops[$urandom % 5], 4'($urandom), 4'hF, 9'($urandom), 9'($urandom)), $urandom, $urandom);
        end
        $display("Test random traffic done");
        i_instr_valid <= 1'b0;
        for (k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge i_core_clk);
        check(32'(exp_q.size()), 32'h0, "pending notes");
        test_done();
    end

endmodule : move_field_insert_unit_bench
